// file: slmc_asserts.sv
// checker: select, mode line and register output properties of the mode control block
`timescale 1ns/1ps
`default_nettype none
module slmc_asserts
    import slmc_pkg::*;
(
    input wire logic                           clk,
    input wire logic                           sys_rst,
    input wire logic                           psel,
    input wire logic                           penable,
    input wire logic                           pwrite,
    input wire logic                           pready,
    input wire logic                           pslverr,
    input wire logic                           mode_line_bit0,
    input wire logic                           mode_line_bit1,
    input wire logic                           mode_line_bit2_out,
    input wire logic                           mode_line_bit2_oe,
    input wire logic [SLMC_NCH*2-1:0]          driver_select_n,
    input wire slmc_chan_ctrl_type [SLMC_NCH-1:0] chan_ctrl,
    input wire logic                           synth_off_bit
);
    // ********
    // helpers
    // ********
    localparam int PH = SLMC_PHASE_CYC;
    logic [3:0] lo;
    logic [3:0] hi;
    logic [7:0] lo_cnt_r;
    logic       wr;
    // per channel decode of the ternary select
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lo[i] = driver_select_n[2*i +: 2] == SLMC_SEL_LOW;
            hi[i] = driver_select_n[2*i +: 2] == SLMC_SEL_HIGH;
        end
    end
    assign wr = psel && penable && pwrite;
    // counts the send phase instead of a long repetition
    always_ff @(posedge clk) begin
        if (sys_rst || !(|lo)) lo_cnt_r <= 8'h00;
        else lo_cnt_r <= lo_cnt_r + 8'h01;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ********
    // properties
    // ********
    chk_one_select: assert property ($onehot0(driver_select_n))
        else $error("two selects active");
    chk_oe_read: assert property (mode_line_bit2_oe == !(|hi))
        else $error("bit2 direction wrong");
    chk_read_lines: assert property (|hi |-> mode_line_bit0 && mode_line_bit1)
        else $error("read lines low");
    chk_mode_hold: assert property (|lo && $past(|lo) |->
        $stable({mode_line_bit2_out, mode_line_bit1, mode_line_bit0}))
        else $error("mode lines moved");
    chk_send_len: assert property ($fell(|lo) |-> $past(lo_cnt_r) == 8'(PH - 1))
        else $error("send phase length wrong");
    chk_send_max: assert property (|lo |-> lo_cnt_r < 8'(PH))
        else $error("send phase too long");
    chk_send_read: assert property ($fell(|lo) |-> hi == $past(lo))
        else $error("no read after send");
    chk_gap_mid: assert property ($fell(|hi) |-> (driver_select_n == 8'h00) [*8])
        else $error("no idle gap after read");
    chk_ctrl_cause: assert property ($changed(chan_ctrl) |-> $past(wr) || $past(wr, 2)
        || $past(sys_rst) || $past(sys_rst, 2))
        else $error("codec mode moved unbidden");
    chk_synth_cause: assert property ($changed(synth_off_bit) |-> $past(wr) || $past(wr, 2))
        else $error("synth off moved unbidden");
    chk_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
        else $error("ready pulse wrong");
    cover property ($fell(|hi));
    cover property (pslverr);
    cover property ($rose(synth_off_bit));
endmodule
bind slmc_top slmc_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .mode_line_bit0(mode_line_bit0), .mode_line_bit1(mode_line_bit1),
    .mode_line_bit2_out(mode_line_bit2_out), .mode_line_bit2_oe(mode_line_bit2_oe),
    .driver_select_n(driver_select_n), .chan_ctrl(chan_ctrl),
    .synth_off_bit(synth_off_bit));
`default_nettype wire

// file: slmc_line_driver_model.sv
// model: four line drivers sharing the mode lines
`timescale 1ns/1ps
`default_nettype none
module slmc_line_driver_model
    import slmc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] driver_select_n,
    input  wire logic       mode_line_bit0,
    input  wire logic       mode_line_bit1,
    input  wire logic       mode_line_bit2,
    input  wire logic [3:0] hot,
    output logic            pin_val,
    output logic [3:0][2:0] last_mode,
    output logic [3:0][7:0] nrd
);
    logic [3:0]      hi_r  = '0;
    logic [3:0]      off_r = '0;
    logic [3:0][7:0] cnt_r = '0;
    logic            tog_r = 1'b0;
    assign nrd = cnt_r;
    // take the mode while selected low, count finished read phases
    always @(posedge clk) begin
        tog_r <= ~tog_r;
        for (int c = 0; c < 4; c++) begin
            if (driver_select_n[2*c +: 2] == SLMC_SEL_LOW)
                last_mode[c] <= {mode_line_bit2, mode_line_bit1, mode_line_bit0};
            hi_r[c] <= driver_select_n[2*c +: 2] == SLMC_SEL_HIGH;
            if (hi_r[c] && driver_select_n[2*c +: 2] != SLMC_SEL_HIGH)
                cnt_r[c] <= cnt_r[c] + 8'h01;
            off_r[c] <= hot[c];
        end
    end
    // released line toggles so a stale level never passes
    always_comb begin
        pin_val = tog_r;
        for (int c = 0; c < 4; c++)
            if (driver_select_n[2*c +: 2] == SLMC_SEL_HIGH && mode_line_bit1 && mode_line_bit0)
                pin_val = hot[c];
    end
endmodule
`default_nettype wire

// file: slmc_pkg.sv
// package: offsets, field positions, modes and timing for subscriber line mode control
package slmc_pkg;

    // ************************************************************
    // register offsets (byte addresses, one word each)
    // ************************************************************
    localparam logic [11:0] SLMC_CHAN_STRIDE         = 12'h0_010;
    localparam logic [11:0] SLMC_OFF_CHAN_MODE       = 12'h0_000;
    localparam logic [11:0] SLMC_OFF_CHAN_RING_CTRL  = 12'h0_004;
    localparam logic [11:0] SLMC_OFF_CHAN_IRQ_MASK   = 12'h0_008;
    localparam logic [11:0] SLMC_OFF_CHAN_IRQ_STATUS = 12'h0_00C;
    localparam logic [11:0] SLMC_OFF_GLOBAL_CFG_ONE  = 12'h0_100;
    localparam logic [11:0] SLMC_OFF_CI_DOWNSTREAM   = 12'h0_104;
    localparam logic [11:0] SLMC_OFF_IRQ_EVENT       = 12'h0_108;

    // ************************************************************
    // channel mode register fields, then ring, mask and global config bits
    // ************************************************************
    localparam int SLMC_BIT_SM_LSB   = 0;
    localparam int SLMC_BIT_SCAN_EN  = 3;
    localparam int SLMC_BIT_PDOWN    = 4;
    localparam int SLMC_BIT_STANDBY  = 5;
    localparam int SLMC_BIT_ACTIVE   = 6;
    localparam int SLMC_BIT_RAMP     = 7;
    localparam int SLMC_BIT_RING     = 0;
    localparam int SLMC_BIT_OVERHEAT = 0;
    localparam int SLMC_BIT_SYNTHOFF = 0;
    localparam int SLMC_BIT_SERIAL   = 1;
    // downstream c/i word: [1:0] channel, [4:2] state, [5] scan enable
    localparam int SLMC_CI_CH_LSB    = 0;
    localparam int SLMC_CI_SM_LSB    = 2;
    localparam int SLMC_CI_SCAN_BIT  = 5;

    localparam logic [7:0]  SLMC_RST_CHAN_MODE = 8'h0_017;
    localparam logic [0:0]  SLMC_RST_MASK      = 1'h1;
    localparam int          SLMC_NCH           = 4;

    // ************************************************************
    // line driver modes as driven on mode lines bit2..bit0
    // ************************************************************
    typedef enum logic [2:0] {
        SLMC_LS_ACTIVE   = 3'b000,
        SLMC_LS_EXT_RING = 3'b001,
        SLMC_LS_INT_RING = 3'b010,
        SLMC_LS_RING_OPN = 3'b011,
        SLMC_LS_TIP_OPN  = 3'b100,
        SLMC_LS_INT_TEST = 3'b101,
        SLMC_LS_STANDBY  = 3'b110,
        SLMC_LS_PDOWN    = 3'b111
    } slmc_line_state_type;

    // ternary select encoding per channel
    typedef enum logic [1:0] {
        SLMC_SEL_MID  = 2'b00,
        SLMC_SEL_LOW  = 2'b01,
        SLMC_SEL_HIGH = 2'b10
    } slmc_sel_type;

    // scan sequencer states
    typedef enum logic [1:0] {
        SLMC_ST_IDLE  = 2'b00,
        SLMC_ST_WRITE = 2'b01,
        SLMC_ST_READ  = 2'b10,
        SLMC_ST_GAP   = 2'b11
    } slmc_state_type;

    // ************************************************************
    // timing: each select phase lasts a fixed time
    // ************************************************************
    localparam int SLMC_CLK_MHZ    = 25;
    localparam int SLMC_PHASE_NS   = 1000;
    localparam int SLMC_PHASE_CYC  = (SLMC_PHASE_NS * SLMC_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] SLMC_PHASE_LAST = 8'(SLMC_PHASE_CYC - 1);

    // per-channel codec mode outputs
    typedef struct packed {
        logic power_down;
        logic standby;
        logic active;
        logic ramp;
        logic ring;
        logic enabled;
    } slmc_chan_ctrl_type;

endpackage

// file: slmc_top.sv
// top: apb registers, scan sequencer and mode lines for four line drivers
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RULE_01] 3-bit line state per channel, from register or serial word
// [RULE_02] scan on: select low sends mode, high reads back
// [RULE_03] scan off: select rests at middle, no transfer
// [RULE_04] 000..011: active, external ring, internal ring, ring open
// [RULE_05] 100..111: tip open, internal test, low power standby, power down
// [RULE_06] select high, bits 1,0 high: bit 2 returns temperature, stored
// [RULE_07] line driver shuts down above its temperature limit
// [RULE_08] overheat rising edge raises an event unless masked
// [RULE_09] five codec mode bits: power down, standby, active, ramp, ring
// [RULE_10] power down stops only that channel
// [RULE_11] system should stop clocks with all channels powered down
// [RULE_12] two mode register writes leave power down; code leaves it on one write with bit 4 low
// [RULE_13] codec standby keeps only off-hook compare
// [RULE_14] driver standby keeps only off-hook sensing
// [RULE_15] ramp bit enables the ramp generator
// [RULE_16] synth off bit stops the pll and signal processing
// [RULE_17] external ring mode returns ring trip on its own line
// [RULE_18] bit 2 line drives while select low, input while high
// [RULE_19] mask high blocks the event, mask low passes it
// [RULE_20] one select at most leaves the middle level
module slmc_top
    import slmc_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      mode_line_bit2_in,
    output logic                           mode_line_bit0,
    output logic                           mode_line_bit1,
    output logic                           mode_line_bit2_out,
    output logic                           mode_line_bit2_oe,
    output logic      [SLMC_NCH*2-1:0]     driver_select_n,
    output logic      [SLMC_NCH-1:0]       overheat_event,
    output slmc_chan_ctrl_type [SLMC_NCH-1:0] chan_ctrl,
    output logic                           synth_off_bit
);

    // ************************************************************
    // register storage
    // ************************************************************
    logic [7:0]          chan_mode_r      [SLMC_NCH];
    logic [SLMC_NCH-1:0] ring_r;
    logic [SLMC_NCH-1:0] overheat_irq_mask_r;
    logic [SLMC_NCH-1:0] overheat_flag_r;
    logic                synth_off_r;
    logic                serial_mode_r;
    logic [SLMC_NCH-1:0] event_r;

    logic                apb_acc;
    logic                apb_wr;
    logic                apb_rd;
    logic [1:0]          ch_idx;
    logic [11:0]         ch_off;
    logic                in_chan;
    logic                addr_ok;

    // first access cycle decodes reads and errors; writes land with pready
    assign apb_acc = psel && penable && !pready;
    assign apb_wr  = psel && penable && pready && pwrite;
    assign apb_rd  = apb_acc && !pwrite;
    assign ch_idx  = paddr[5:4];
    assign ch_off  = paddr & 12'h0_00F;
    assign in_chan = (paddr < 12'h0_040);

    // address decode for legality
    always_comb begin
        if (in_chan && ch_off[1:0] == 2'b00) begin
            addr_ok = 1'b1;
        end else if (paddr == SLMC_OFF_GLOBAL_CFG_ONE) begin
            addr_ok = 1'b1;
        end else if (paddr == SLMC_OFF_CI_DOWNSTREAM) begin
            addr_ok = 1'b1;
        end else if (paddr == SLMC_OFF_IRQ_EVENT) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // ************************************************************
    // apb handshake
    // ************************************************************
    // pready pulses in the second access cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= apb_acc && !addr_ok;
        end
    end

    // read data mux, registered in the first access cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (apb_rd) begin
            prdata <= 32'h0000_0000;
            if (in_chan && ch_off == SLMC_OFF_CHAN_MODE) begin
                prdata <= {24'h00_0000, chan_mode_r[ch_idx]};
            end else if (in_chan && ch_off == SLMC_OFF_CHAN_RING_CTRL) begin
                prdata <= {31'h0000_0000, ring_r[ch_idx]};
            end else if (in_chan && ch_off == SLMC_OFF_CHAN_IRQ_MASK) begin
                prdata <= {31'h0000_0000, overheat_irq_mask_r[ch_idx]};
            end else if (in_chan && ch_off == SLMC_OFF_CHAN_IRQ_STATUS) begin
                prdata <= {31'h0000_0000, overheat_flag_r[ch_idx]};
            end else if (paddr == SLMC_OFF_GLOBAL_CFG_ONE) begin
                prdata <= {30'h0000_0000, serial_mode_r, synth_off_r};
            end else if (paddr == SLMC_OFF_IRQ_EVENT) begin
                prdata <= {28'h000_0000, event_r};
            end
        end
    end

    // ************************************************************
    // per-channel configuration
    // ************************************************************
    logic                ci_wr;
    logic [1:0]          ci_ch;
    assign ci_wr = apb_wr && paddr == SLMC_OFF_CI_DOWNSTREAM && serial_mode_r;
    assign ci_ch = pwdata[SLMC_CI_CH_LSB +: 2];

    genvar g;
    generate
        for (g = 0; g < SLMC_NCH; g++) begin : g_ch
            logic hit;
            logic pd;
            assign hit = apb_wr && in_chan && ch_idx == 2'(g);
            assign pd  = chan_mode_r[g][SLMC_BIT_PDOWN];
            // mode word: the register port is ignored in serial mode
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    chan_mode_r[g] <= SLMC_RST_CHAN_MODE;
                end else if (hit && !serial_mode_r && ch_off == SLMC_OFF_CHAN_MODE) begin
                    chan_mode_r[g] <= pwdata[7:0]; // [RULE_01] [RULE_12]
                end else if (ci_wr && ci_ch == 2'(g)) begin
                    chan_mode_r[g][2:0] <= pwdata[SLMC_CI_SM_LSB +: 3]; // [RULE_01]
                    chan_mode_r[g][SLMC_BIT_SCAN_EN] <= pwdata[SLMC_CI_SCAN_BIT];
                end
            end
            // ring enable and overheat mask
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    ring_r[g]              <= 1'b0;
                    overheat_irq_mask_r[g] <= SLMC_RST_MASK;
                end else begin
                    if (hit && ch_off == SLMC_OFF_CHAN_RING_CTRL) begin
                        ring_r[g] <= pwdata[SLMC_BIT_RING]; // [RULE_12]
                    end
                    if (hit && ch_off == SLMC_OFF_CHAN_IRQ_MASK) begin
                        overheat_irq_mask_r[g] <= pwdata[SLMC_BIT_OVERHEAT];
                    end
                end
            end
            // codec mode outputs; power down gates only this channel
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    chan_ctrl[g] <= '0;
                end else begin
                    chan_ctrl[g].power_down <= pd; // [RULE_09] [RULE_10]
                    chan_ctrl[g].standby    <= chan_mode_r[g][SLMC_BIT_STANDBY] && !pd; // [RULE_13]
                    chan_ctrl[g].active     <= chan_mode_r[g][SLMC_BIT_ACTIVE] && !pd; // [RULE_09]
                    chan_ctrl[g].ramp       <= chan_mode_r[g][SLMC_BIT_RAMP] && !pd; // [RULE_15]
                    chan_ctrl[g].ring       <= ring_r[g] && !pd; // [RULE_09]
                    chan_ctrl[g].enabled    <= !pd && !synth_off_r; // [RULE_10] [RULE_16]
                end
            end
        end
    endgenerate

    // global configuration
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            synth_off_r   <= 1'b0;
            serial_mode_r <= 1'b0;
            synth_off_bit <= 1'b0;
        end else begin
            if (apb_wr && paddr == SLMC_OFF_GLOBAL_CFG_ONE) begin
                synth_off_r   <= pwdata[SLMC_BIT_SYNTHOFF]; // [RULE_16]
                serial_mode_r <= pwdata[SLMC_BIT_SERIAL];
            end
            synth_off_bit <= synth_off_r; // [RULE_16]
        end
    end

    // ************************************************************
    // scan sequencer: one channel at a time on the shared mode lines
    // ************************************************************
    slmc_state_type state_r;
    logic [1:0]     cur_ch_r;
    logic [7:0]     phase_cnt_r;
    logic           phase_done;
    logic           cur_scan;
    logic [2:0]     cur_state;
    logic           overtemp_read;
    assign phase_done    = phase_cnt_r == SLMC_PHASE_LAST;
    assign cur_scan      = chan_mode_r[cur_ch_r][SLMC_BIT_SCAN_EN];
    assign cur_state     = chan_mode_r[cur_ch_r][2:0];

    // state and channel pointer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r     <= SLMC_ST_IDLE;
            cur_ch_r    <= 2'b00;
            phase_cnt_r <= 8'h00;
        end else begin
            phase_cnt_r <= (state_r == SLMC_ST_IDLE || phase_done) ? 8'h00 : phase_cnt_r + 8'h01;
            case (state_r)
                SLMC_ST_IDLE: begin
                    if (cur_scan) begin
                        state_r <= SLMC_ST_WRITE; // [RULE_02]
                    end else begin
                        cur_ch_r <= cur_ch_r + 2'b01; // [RULE_03]
                    end
                end
                SLMC_ST_WRITE: begin
                    if (phase_done) begin
                        state_r <= SLMC_ST_READ;
                    end
                end
                SLMC_ST_READ: begin
                    if (phase_done) begin
                        state_r <= SLMC_ST_GAP;
                    end
                end
                default: begin
                    // gap keeps all selects at middle before the next channel
                    if (phase_done) begin
                        state_r  <= SLMC_ST_IDLE;
                        cur_ch_r <= cur_ch_r + 2'b01; // [RULE_20]
                    end
                end
            endcase
        end
    end

    // pins: only the current channel ever leaves the middle level
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            driver_select_n    <= '0;
            mode_line_bit0     <= 1'b1;
            mode_line_bit1     <= 1'b1;
            mode_line_bit2_out <= 1'b1;
            mode_line_bit2_oe  <= 1'b1;
        end else begin
            for (int i = 0; i < SLMC_NCH; i++) begin
                driver_select_n[i*2 +: 2] <= SLMC_SEL_MID; // [RULE_03] [RULE_20]
            end
            if (state_r == SLMC_ST_WRITE) begin
                driver_select_n[cur_ch_r*2 +: 2] <= SLMC_SEL_LOW; // [RULE_02]
                {mode_line_bit2_out, mode_line_bit1, mode_line_bit0}
                    <= cur_state; // [RULE_04] [RULE_05] [RULE_14]
                mode_line_bit2_oe <= 1'b1; // [RULE_18]
            end else if (state_r == SLMC_ST_READ) begin
                driver_select_n[cur_ch_r*2 +: 2] <= SLMC_SEL_HIGH; // [RULE_02]
                mode_line_bit1    <= 1'b1; // [RULE_06]
                mode_line_bit0    <= 1'b1; // [RULE_06]
                mode_line_bit2_oe <= 1'b0; // [RULE_18]
            end else begin
                mode_line_bit2_oe <= 1'b1;
            end
        end
    end

    // ************************************************************
    // overheat capture and events
    // ************************************************************
    // sample at the end of the read phase
    assign overtemp_read = state_r == SLMC_ST_READ && phase_done;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            overheat_flag_r <= '0;
        end else if (overtemp_read) begin
            overheat_flag_r[cur_ch_r] <= mode_line_bit2_in; // [RULE_06] [RULE_07]
        end
    end

    // sticky event on 0 to 1; write one clears, a new edge wins over clear
    always_ff @(posedge clk) begin
        for (int i = 0; i < SLMC_NCH; i++) begin
            if (sys_rst) begin
                event_r[i] <= 1'b0;
            end else if (overtemp_read && cur_ch_r == 2'(i) && mode_line_bit2_in
                         && !overheat_flag_r[i] && !overheat_irq_mask_r[i]) begin
                event_r[i] <= 1'b1; // [RULE_08] [RULE_19]
            end else if (apb_wr && paddr == SLMC_OFF_IRQ_EVENT && pwdata[i]) begin
                event_r[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            overheat_event <= '0;
        end else begin
            overheat_event <= event_r & ~overheat_irq_mask_r; // [RULE_19]
        end
    end

endmodule

`default_nettype wire

// file: tb_top.sv
// testbench: register access, scan traffic, overheat events and resets
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import slmc_pkg::*;
    typedef struct packed {logic [1:0] ch; logic [7:0] mode; logic hot;} slmc_row_type;
    logic                     clk = 1'b0;
    logic                     sys_rst = 1'b1;
    logic                     psel = 1'b0;
    logic                     penable = 1'b0;
    logic                     pwrite = 1'b0;
    logic [11:0]              paddr = '0;
    logic [31:0]              pwdata = '0;
    logic [31:0]              prdata, rd;
    logic                     pready, pslverr, er, b0, b1, b2o, b2oe, m2, pin_val, synth;
    logic [7:0]               sel_n;
    logic [3:0]               ev;
    logic [3:0]               hot = '0;
    slmc_chan_ctrl_type [3:0] cc;
    logic [3:0][2:0]          lm;
    logic [3:0][7:0]          nrd;
    logic [7:0]               shadow [4] = '{4{SLMC_RST_CHAN_MODE}};
    slmc_row_type             r;
    int                       err_total = 0;
    int                       cmp_count = 0;
    int                       busy;
    // channel, mode word, reported temperature
    slmc_row_type rows [8] = '{{2'd0, 8'h18, 1'b0}, {2'd1, 8'h29, 1'b1}, {2'd2, 8'h4A, 1'b0},
        {2'd3, 8'h8B, 1'b1}, {2'd0, 8'h1C, 1'b0}, {2'd1, 8'h2D, 1'b1}, {2'd2, 8'h4E, 1'b0},
        {2'd3, 8'h8F, 1'b1}};
    assign m2 = b2oe ? b2o : pin_val;
    slmc_top u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mode_line_bit2_in(m2), .mode_line_bit0(b0), .mode_line_bit1(b1),
        .mode_line_bit2_out(b2o), .mode_line_bit2_oe(b2oe), .driver_select_n(sel_n),
        .overheat_event(ev), .chan_ctrl(cc), .synth_off_bit(synth));
    slmc_line_driver_model u_drv (.clk(clk), .driver_select_n(sel_n), .mode_line_bit0(b0),
        .mode_line_bit1(b1), .mode_line_bit2(m2), .hot(hot), .pin_val(pin_val),
        .last_mode(lm), .nrd(nrd));
    always #20 clk = ~clk;
    task automatic final_report();
        if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            final_report();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // wait for one more finished read phase of a channel
    task automatic wait_read(input logic [1:0] ch);
        logic [7:0] n0;
        int n;
        n0 = nrd[ch];
        n = 0;
        while (nrd[ch] === n0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n >= 400) begin
            err_total++;
            final_report();
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, SLMC_OFF_CHAN_MODE, '0);
        check(rd, 32'(SLMC_RST_CHAN_MODE));
        apb(1'b0, SLMC_OFF_CHAN_IRQ_MASK, '0);
        check(rd, 32'h0000_0001);
        check(cc[0].power_down, 1'b1);
        // table rows: all line states and codec mode bits except ring, mask set
        for (int i = 0; i < 8; i++) begin
            r = rows[i];
            hot[r.ch] <= r.hot;
            shadow[r.ch] = r.mode;
            apb(1'b1, SLMC_CHAN_STRIDE * r.ch, {24'h0000_00, r.mode});
            wait_read(r.ch);
            check(lm[r.ch], r.mode[2:0]);
            apb(1'b0, SLMC_CHAN_STRIDE * r.ch + SLMC_OFF_CHAN_IRQ_STATUS, '0);
            check(rd, r.hot);
            check(ev, 4'h0);
            for (int c = 0; c < 4; c++)
                check({cc[c].power_down, cc[c].standby, cc[c].active, cc[c].ramp},
                    {shadow[c][4], shadow[c][5], shadow[c][6], shadow[c][7]});
            shadow[r.ch] = r.mode & 8'hF7;
            apb(1'b1, SLMC_CHAN_STRIDE * r.ch, {24'h0000_00, shadow[r.ch]});
        end
        // unmasked rising temperature raises and clears an event
        apb(1'b1, 12'h028, '0);
        hot[2] <= 1'b1;
        apb(1'b1, 12'h020, {24'h0000_00, shadow[2] | 8'h08});
        wait_read(2'd2);
        apb(1'b0, SLMC_OFF_IRQ_EVENT, '0);
        check(ev, 4'h4);
        check(rd, 32'h0000_0004);
        apb(1'b1, SLMC_OFF_IRQ_EVENT, 32'h0000_0004);
        apb(1'b1, 12'h020, {24'h0000_00, shadow[2]});
        check(ev, 4'h0);
        // with no channel enabled every select rests at middle
        repeat (3 * SLMC_PHASE_CYC) @(posedge clk);
        busy = 0;
        repeat (4 * SLMC_PHASE_CYC) begin
            @(posedge clk);
            if (sel_n !== 8'h00) busy++;
        end
        check(busy, 0);
        // serial mode: register write refused, c/i word accepted
        apb(1'b1, SLMC_OFF_GLOBAL_CFG_ONE, 32'h0000_0002);
        apb(1'b1, SLMC_OFF_CHAN_MODE, 32'h0000_000D);
        apb(1'b1, SLMC_OFF_CI_DOWNSTREAM, 32'h0000_0033);
        wait_read(2'd3);
        check(lm[3], 3'b100);
        check(cc[0].power_down, 1'b1);
        apb(1'b1, SLMC_OFF_CI_DOWNSTREAM, 32'h0000_0013);
        // synth off, ring bit, unmapped place
        apb(1'b1, SLMC_OFF_GLOBAL_CFG_ONE, 32'h0000_0001);
        apb(1'b1, SLMC_CHAN_STRIDE + SLMC_OFF_CHAN_RING_CTRL, 32'h0000_0001);
        repeat (2) @(posedge clk);
        check(synth, 1'b1);
        check(cc[1].ring, 1'b1);
        apb(1'b1, SLMC_OFF_GLOBAL_CFG_ONE, '0);
        apb(1'b0, 12'h0FC, '0);
        check({er, rd}, {1'b1, 32'h0000_0000});
        check(synth, 1'b0);
        // mid-scan reset: selects to middle, modes to default
        apb(1'b1, SLMC_CHAN_STRIDE, 32'h0000_0029);
        repeat (SLMC_PHASE_CYC) @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        check(sel_n, 8'h00);
        sys_rst <= 1'b0;
        apb(1'b0, SLMC_CHAN_STRIDE, '0);
        check(rd, 32'(SLMC_RST_CHAN_MODE));
        check(cc[1].power_down, 1'b1);
        final_report();
    end
endmodule
`default_nettype wire
